/* File: csp_serial_port.sv */
module csp_serial_port #(
   parameter int DIV_W = 12,
   parameter int WORDS = 4
) (
   // clock, reset, enable
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic                clk_en,
   // register port
   input  wire logic [csp_pkg::AW-1:0] reg_addr,
   input  wire logic [csp_pkg::DW-1:0] reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [csp_pkg::DW-1:0]   reg_rdata,
   // codec pins
   input  wire logic                bit_clock_pin_in,
   input  wire logic                frame_sync_pin_in,
   input  wire logic                serial_in_pin,
   output csp_pkg::csp_pins_s       pins,
   // buffer event toward cpu
   output logic                     buffer_irq
);
   import csp_pkg::*;

   //----------------------------------------
   // registers and decode
   //----------------------------------------
   logic [DW-1:0]    ctl1_ff;
   logic [DW-1:0]    ctl2_ff;
   logic [DW-1:0]    ctl3_ff;
   logic [DW-1:0]    tmask_ff;
   logic [DW-1:0]    rmask_ff;
   logic [DW-1:0]    tx_reg_ff [WORDS];
   logic [DW-1:0]    rx_reg_ff [WORDS];
   logic [DW-1:0]    tx_buf_ff [WORDS];
   logic [DW-1:0]    rx_buf_ff [WORDS];
   logic [DW-1:0]    rdata_ff;
   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] div_cnt_ff;
   logic             gen_clk_ff;
   logic             module_on;
   logic             bit_clock_direction;
   logic             sample_edge_select;
   logic             frame_sync_direction;
   logic             idle_output_drive;
   csp_mode_e        frame_protocol_select;
   logic [3:0]       slot_bit_count;
   logic [3:0]       frame_slot_count;
   logic [1:0]       buffered_word_count;
   assign module_on             = ctl1_ff[C1_ON];
   assign bit_clock_direction   = ctl1_ff[C1_SCKD];
   assign sample_edge_select    = ctl1_ff[C1_EDGE];
   assign frame_sync_direction  = ctl1_ff[C1_FSD];
   assign idle_output_drive     = ctl1_ff[C1_IDLE];
   assign frame_protocol_select = csp_mode_e'(ctl1_ff[C1_MODE+:2]);
   assign slot_bit_count        = ctl2_ff[C2_WS+:4];
   assign frame_slot_count      = ctl2_ff[C2_FSG+:4];
   assign buffered_word_count   = ctl2_ff[C2_BUFFERED_WORD_COUNT+:2];
   assign div                   = ctl3_ff[C3_DIV+:DIV_W];
   logic             run_ff;
   logic [4:0]       bit_ff;
   logic [3:0]       slot_ff;
   logic [1:0]       ptr_ff;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ctl1_ff  <= RST_REG;
         ctl2_ff  <= RST_REG;
         ctl3_ff  <= RST_REG;
         tmask_ff <= RST_REG;
         rmask_ff <= RST_REG;
         for (int i = 0; i < WORDS; i++)
            tx_reg_ff[i] <= RST_REG;
      end
      else if (clk_en && reg_wr)
      begin
         if (reg_addr == OFS_CTL1)
            ctl1_ff <= reg_wdata;
         else if (reg_addr == OFS_CTL2)
            ctl2_ff <= reg_wdata;
         else if (reg_addr == OFS_CTL3)
            ctl3_ff <= reg_wdata;
         else if (reg_addr[3:2] == OFS_TX0[3:2])
            tx_reg_ff[reg_addr[1:0]] <= reg_wdata;
         else if (reg_addr == OFS_TMASK)
            tmask_ff <= reg_wdata;
         else if (reg_addr == OFS_RMASK)
            rmask_ff <= reg_wdata;
      end
   end

   // transmit words read as zero, unmapped reads zero
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rdata_ff <= RST_REG;
      else if (clk_en)
      begin
         if (!reg_rd)
            rdata_ff <= RST_REG;
         else if (reg_addr == OFS_CTL1)
            rdata_ff <= ctl1_ff;
         else if (reg_addr == OFS_CTL2)
            rdata_ff <= ctl2_ff;
         else if (reg_addr == OFS_CTL3)
            rdata_ff <= ctl3_ff;
         else if (reg_addr[3:2] == OFS_RX0[3:2])
            rdata_ff <= rx_reg_ff[reg_addr[1:0]];
         else if (reg_addr == OFS_TMASK)
            rdata_ff <= tmask_ff;
         else if (reg_addr == OFS_RMASK)
            rdata_ff <= rmask_ff;
         else if (reg_addr == OFS_STAT)
            rdata_ff <= {1'b0, run_ff, ptr_ff, slot_ff, 3'h0, bit_ff};
         else
            rdata_ff <= RST_REG;
      end
   end
   assign reg_rdata = rdata_ff;

   //----------------------------------------
   // bit clock generator
   //----------------------------------------
   // runs even with the module off, so a codec can be clocked first
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         div_cnt_ff <= '0;
         gen_clk_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (div == '0)
         begin
            div_cnt_ff <= '0;
            gen_clk_ff <= 1'b0;
         end
         else if (div_cnt_ff >= div)
         begin
            div_cnt_ff <= '0;
            gen_clk_ff <= ~gen_clk_ff;
         end
         else
            div_cnt_ff <= div_cnt_ff + 1'b1;
      end
   end

   //----------------------------------------
   // edges and slot geometry
   //----------------------------------------
   logic       sck;
   logic       sck_prev_ff;
   logic       on_prev_ff;
   logic       smp;
   logic       drv;
   logic [4:0] slot_len;
   logic [3:0] last_slot;
   logic       bit_last;
   logic       frame_last;
   logic       slot_end;
   logic       slot_used;
   logic       xfer;
   logic       start;
   logic       fs_ff;
   logic       fs_smp_ff;
   logic       pend_ff;
   logic [1:0] nxt_ptr;
   logic [3:0] nxt_slot;
   logic [DW-1:0] tx_word;
   logic [DW-1:0] rx_sh_ff;
   logic [DW-1:0] tx_sh_ff;
   logic [DW-1:0] rx_word;
   logic [4:0]    rx_bits;
   // external clock path is taken as synchronous to clk_sys
   assign sck = bit_clock_direction ? bit_clock_pin_in : gen_clk_ff;
   assign smp = sample_edge_select ? (sck & ~sck_prev_ff)
                                   : (~sck & sck_prev_ff);
   assign drv = sample_edge_select ? (~sck & sck_prev_ff)
                                   : (sck & ~sck_prev_ff);
   always_comb
   begin
      slot_len  = {1'b0, slot_bit_count} + 5'h01;
      last_slot = frame_slot_count;
      if (frame_protocol_select == MODE_AC16)
      begin
         slot_len  = AC_SLOT0_LEN;
         last_slot = AC16_LAST;
      end
      else if (frame_protocol_select == MODE_AC20)
      begin
         slot_len  = (slot_ff == 4'h0) ? AC_SLOT0_LEN : AC20_LEN;
         last_slot = AC20_LAST;
      end
   end
   assign bit_last   = bit_ff == slot_len - 5'h01;
   assign frame_last = bit_last && slot_ff == last_slot;
   assign slot_end   = drv && run_ff && bit_last;
   assign slot_used  = tmask_ff[slot_ff] | rmask_ff[slot_ff];
   assign start      = drv && (frame_sync_direction ? pend_ff : fs_ff);
   assign nxt_slot   = start ? 4'h0 : slot_ff + 4'h1;
   always_comb
   begin
      nxt_ptr = ptr_ff;
      if (slot_end && slot_used)
         nxt_ptr = (ptr_ff == buffered_word_count) ? 2'h0 : ptr_ff + 2'h1;
   end
   assign xfer = module_on && ((!on_prev_ff) ||
                 (slot_end && slot_used && ptr_ff == buffered_word_count));
   // on a block boundary the new transmit word comes straight from software
   assign tx_word = xfer ? tx_reg_ff[nxt_ptr] : tx_buf_ff[nxt_ptr];
   // slots beyond 16 bits keep only their first 16 received bits
   assign rx_bits = (slot_len > 5'h10) ? 5'h10 : slot_len;
   assign rx_word = rx_sh_ff << (5'h10 - rx_bits);

   //----------------------------------------
   // frame sequencing and shifting
   //----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sck_prev_ff <= 1'b0;
         on_prev_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         sck_prev_ff <= sck;
         on_prev_ff  <= module_on;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         run_ff    <= 1'b0;
         bit_ff    <= 5'h00;
         slot_ff   <= 4'h0;
         fs_ff     <= 1'b0;
         fs_smp_ff <= 1'b0;
         pend_ff   <= 1'b0;
         rx_sh_ff  <= RST_REG;
         tx_sh_ff  <= RST_REG;
      end
      else if (clk_en)
      begin
         if (!module_on)
         begin
            run_ff    <= 1'b0;
            bit_ff    <= 5'h00;
            slot_ff   <= 4'h0;
            fs_ff     <= 1'b0;
            fs_smp_ff <= 1'b0;
            pend_ff   <= 1'b0;
            tx_sh_ff  <= RST_REG;
         end
         else
         begin
            if (smp)
            begin
               fs_smp_ff <= frame_sync_pin_in;
               if (frame_sync_direction && frame_sync_pin_in && !fs_smp_ff)
                  pend_ff <= 1'b1;
               if (run_ff && bit_ff < 5'h10)
                  rx_sh_ff <= {rx_sh_ff[DW-2:0], serial_in_pin};
            end
            if (drv)
            begin
               // sync goes high one bit before slot zero of each frame
               if (!frame_sync_direction)
                  fs_ff <= (!run_ff && !fs_ff) || (run_ff && slot_ff == last_slot &&
                           bit_ff == slot_len - 5'h02);
               if (start)
                  pend_ff <= 1'b0;
               if (start || slot_end)
               begin
                  run_ff   <= start || !frame_last;
                  bit_ff   <= 5'h00;
                  slot_ff  <= nxt_slot;
                  tx_sh_ff <= tmask_ff[nxt_slot] ? tx_word : RST_REG;
               end
               else if (run_ff)
               begin
                  bit_ff   <= bit_ff + 5'h01;
                  tx_sh_ff <= {tx_sh_ff[DW-2:0], 1'b0};
               end
            end
         end
      end
   end

   //----------------------------------------
   // buffer control unit
   //----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ptr_ff <= 2'h0;
         for (int i = 0; i < WORDS; i++)
         begin
            tx_buf_ff[i] <= RST_REG;
            rx_buf_ff[i] <= RST_REG;
            rx_reg_ff[i] <= RST_REG;
         end
      end
      else if (clk_en)
      begin
         if (!module_on)
            ptr_ff <= 2'h0;
         else
         begin
            ptr_ff <= xfer ? 2'h0 : nxt_ptr;
            for (int i = 0; i < WORDS; i++)
            begin
               if (slot_end && rmask_ff[slot_ff] && ptr_ff == i[1:0])
               begin
                  rx_buf_ff[i] <= rx_word;
                  if (xfer)
                     rx_reg_ff[i] <= rx_word;
               end
               else if (xfer)
                  rx_reg_ff[i] <= rx_buf_ff[i];
               if (xfer)
                  tx_buf_ff[i] <= tx_reg_ff[i];
            end
         end
      end
   end

   //----------------------------------------
   // pins and event
   //----------------------------------------
   csp_pins_s pins_ff;
   logic      irq_ff;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         pins_ff <= '0;
         irq_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         irq_ff         <= xfer;
         pins_ff.sck_o  <= gen_clk_ff;
         pins_ff.sck_oe <= (module_on || div != '0) && !bit_clock_direction;
         pins_ff.fs_o   <= fs_ff;
         pins_ff.fs_oe  <= module_on && !frame_sync_direction;
         pins_ff.sdo_o  <= run_ff && tmask_ff[slot_ff] && tx_sh_ff[DW-1];
         // tri-state when idle lets several devices share one data line
         pins_ff.sdo_oe <= module_on && ((run_ff && tmask_ff[slot_ff]) || !idle_output_drive);
      end
   end
   assign pins       = pins_ff;
   assign buffer_irq = irq_ff;

   //----------------------------------------
   // assertions
   //----------------------------------------
   AST_DIV_STOP: assert property (@(posedge clk_sys) disable iff (!nrst)
      (clk_en && div == '0) |=> !gen_clk_ff)
      else $error("bit clock runs with zero divider");
   AST_DIV_PERIOD: assert property (@(posedge clk_sys) disable iff (!nrst)
      ($changed(gen_clk_ff) && $past(div) != '0) |-> $past(div_cnt_ff) >= $past(div))
      else $error("bit clock toggled before divider count");
   AST_SCK_OWN: assert property (@(posedge clk_sys) disable iff (!nrst)
      (clk_en && div != '0 && !bit_clock_direction) |=> pins.sck_oe)
      else $error("clock pin not driven while generator runs");
   AST_SCK_IN: assert property (@(posedge clk_sys) disable iff (!nrst)
      (clk_en && bit_clock_direction) |=> !pins.sck_oe)
      else $error("clock pin driven while set as input");
   AST_IRQ_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
      buffer_irq |=> !buffer_irq)
      else $error("buffer event longer than one cycle");
   AST_WRAP: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(buffer_irq) |-> ptr_ff == 2'h0)
      else $error("pointer not at zero after block transfer");
   AST_OFF_RESET: assert property (@(posedge clk_sys) disable iff (!nrst)
      (clk_en && !module_on) |=> (!run_ff && ptr_ff == 2'h0 && slot_ff == 4'h0))
      else $error("counters not cleared while module off");
   AST_MASTER_START: assert property (@(posedge clk_sys) disable iff (!nrst)
      (clk_en && module_on && drv && fs_ff && !frame_sync_direction)
      |=> (run_ff && slot_ff == 4'h0 && bit_ff == 5'h00))
      else $error("slot zero not started after frame sync");
   AST_AC_LAST: assert property (@(posedge clk_sys) disable iff (!nrst)
      (run_ff && frame_protocol_select == MODE_AC16) |-> slot_ff <= AC16_LAST)
      else $error("AC-Link frame exceeds fixed slot count");

   COV_IRQ:   cover property (@(posedge clk_sys) disable iff (!nrst) buffer_irq);
   COV_FRAME: cover property (@(posedge clk_sys) disable iff (!nrst)
      start && frame_sync_direction);
   COV_AC20:  cover property (@(posedge clk_sys) disable iff (!nrst)
      slot_end && frame_last && frame_protocol_select == MODE_AC20);
endmodule

/* File: csp_pkg.sv */
//----------------------------------------
// Function
// - 12-bit divider sets generated bit clock period
// - divider zero stops the generated bit clock
// - own clock pin when enabled or divider nonzero
// - clock direction bit picks drive or accept
// - bit clock equals clock over 2(div+1)
// - sample falling edge by default, rising when set
// - two-bit field selects framed, I2S, AC-Link modes; the I2S code runs as framed mode
// - slot bit count is field value plus one
// - AC-Link modes ignore slot bit count field
// - frame lasts (bits+1)*(slots+1) bit clocks
// - AC-Link frames are fixed 256 bit clocks
// - four write-only transmit, four receive words
// - left justified, unused low receive bits cleared
// - hidden buffers decouple software from shifting
// - buffered word count field plus one words
// - wrap pointer, swap buffers, signal after block
// - transmit and receive share one pointer
// - shift most significant bit first
// - module off resets bit, slot and pointer counters
// - frame sync direction picks master or slave
// - pointer advances if either slot mask set
//----------------------------------------
package csp_pkg;
   localparam int unsigned DW = 16;
   localparam int unsigned AW = 4;

   // register word offsets
   localparam logic [AW-1:0] OFS_CTL1  = 4'h0;
   localparam logic [AW-1:0] OFS_CTL2  = 4'h1;
   localparam logic [AW-1:0] OFS_CTL3  = 4'h2;
   localparam logic [AW-1:0] OFS_TX0   = 4'h4;
   localparam logic [AW-1:0] OFS_RX0   = 4'h8;
   localparam logic [AW-1:0] OFS_TMASK = 4'hc;
   localparam logic [AW-1:0] OFS_RMASK = 4'hd;
   localparam logic [AW-1:0] OFS_STAT  = 4'he;

   // field positions
   localparam int C1_ON   = 15;
   localparam int C1_SCKD = 10;
   localparam int C1_EDGE = 9;
   localparam int C1_FSD  = 8;
   localparam int C1_IDLE = 6;
   localparam int C1_MODE = 0;
   localparam int C2_WS   = 0;
   localparam int C2_FSG  = 5;
   localparam int C2_BUFFERED_WORD_COUNT = 10;
   localparam int C3_DIV  = 0;

   localparam logic [DW-1:0] RST_REG = 16'h0000;

   // fixed AC-Link framing: 16 + 12*20 or 16*16 = 256 bits
   localparam logic [4:0] AC_SLOT0_LEN = 5'h10;
   localparam logic [4:0] AC20_LEN     = 5'h14;
   localparam logic [3:0] AC16_LAST    = 4'hf;
   localparam logic [3:0] AC20_LAST    = 4'hc;

   typedef enum logic [1:0] {
      MODE_MULTI = 2'b00,
      MODE_I2S   = 2'b01,
      MODE_AC16  = 2'b10,
      MODE_AC20  = 2'b11
   } csp_mode_e;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic fs_o;
      logic fs_oe;
      logic sdo_o;
      logic sdo_oe;
   } csp_pins_s;
endpackage

/* File: csp_codec_model.sv */
module csp_codec_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // link pins seen from the codec
   input  wire logic        sck,
   input  wire logic        fs,
   input  wire logic        sdo,
   output logic             sdi,
   // setup and capture
   input  wire logic        edge_rise,
   input  wire logic [4:0]  nbits,
   output logic [15:0]      cap,
   output logic             cap_stb
);
   timeunit 1ns;
   timeprecision 1ns;
   //----------------------------------------
   // codec: slot zero only, word per frame
   //----------------------------------------
   int          frames;
   int          bitn;
   logic        sck_q;
   logic [15:0] word;
   logic [15:0] sh;

   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sck_q   <= 1'b0;
         bitn    <= 99;
         frames  <= 0;
         sdi     <= 1'b0;
         cap     <= 16'h0000;
         cap_stb <= 1'b0;
         word    <= 16'h0000;
         sh      <= 16'h0000;
      end
      else
      begin
         sck_q   <= sck;
         cap_stb <= 1'b0;
         if (sck !== sck_q && sck === edge_rise)
         begin
            // sample edge; fs is seen here, last data bit too
            if (bitn >= 1 && bitn <= int'(nbits))
               sh <= {sh[14:0], sdo};
            if (bitn == int'(nbits))
            begin
               cap     <= {sh[14:0], sdo} << (16 - int'(nbits));
               cap_stb <= 1'b1;
            end
            if (fs === 1'b1)
            begin
               bitn   <= 0;
               word   <= 16'h9e37 + 16'(frames) * 16'h03b5;
               frames <= frames + 1;
            end
         end
         else if (sck !== sck_q)
         begin
            // drive edge; outside the slot the line wanders
            if (bitn < int'(nbits))
               sdi <= word[15 - bitn];
            else
               sdi <= ~sdi;
            if (bitn < 64)
               bitn <= bitn + 1;
         end
      end
   end
endmodule

/* File: csp_serial_port_tb_top.sv */
module csp_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import csp_pkg::*;

   logic              clk_sys   = 1'b0;
   logic              nrst      = 1'b0;
   logic              cod_nrst  = 1'b0;
   logic              fs_ext    = 1'b0;
   logic [AW-1:0]     reg_addr  = 4'h0;
   logic [DW-1:0]     reg_wdata = 16'h0000;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic [DW-1:0]     reg_rdata;
   csp_pins_s         pins;
   logic              buffer_irq;
   logic              sdi;
   logic              cap_stb;
   logic              edge_r    = 1'b0;
   logic [4:0]        nbits     = 5'h10;
   logic [15:0]       cap;
   logic [15:0]       capq[$];
   int                n_errors  = 0;
   int                num_checks = 0;
   int                n_irq     = 0;
   int                seed      = 32'hea73c1c9;

   always #20 clk_sys = ~clk_sys;

   // pin levels; clock input unused, sync input drives the slave run
   csp_serial_port u_csp_serial_port (
      .clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bit_clock_pin_in(1'b0), .frame_sync_pin_in(fs_ext), .serial_in_pin(sdi),
      .pins(pins), .buffer_irq(buffer_irq));

   csp_codec_model u_csp_codec_model (
      .clk_sys(clk_sys), .nrst(cod_nrst), .sck(pins.sck_o), .fs(pins.fs_o),
      .sdo(pins.sdo_o), .sdi(sdi), .edge_rise(edge_r), .nbits(nbits),
      .cap(cap), .cap_stb(cap_stb));

   always @(negedge clk_sys)
   begin
      if (buffer_irq === 1'b1)
         n_irq++;
      if (cap_stb === 1'b1)
         capq.push_back(cap);
   end

   //----------------------------------------
   // checking and bus tasks
   //----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(negedge clk_sys);
      chk(nm, {16'h0000, e}, {16'h0000, reg_rdata});
   endtask

   task automatic rdbit(input string nm, input int b, input logic e);
      @(posedge clk_sys);
      reg_addr <= OFS_STAT;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(negedge clk_sys);
      chk(nm, {31'h0, e}, {31'h0, reg_rdata[b]});
   endtask

   task automatic wait_irq(input int n);
      int i;
      for (i = 0; i < 20000 && n_irq < n; i++)
         @(posedge clk_sys);
      if (n_irq < n)
      begin
         chk("irq_wait", 1, 0);
         complete_run;
      end
      @(negedge clk_sys);
      chk("irq_width", 0, {31'h0, buffer_irq});
   endtask

   // clk_sys periods between two rises of sck (0) or fs (1)
   task automatic period(input int which, input int exp, input string nm);
      int   i;
      int   t0;
      logic p;
      logic c;
      t0 = -1;
      p  = 1'b1;
      for (i = 0; i < 3000; i++)
      begin
         @(negedge clk_sys);
         c = (which != 0) ? pins.fs_o : pins.sck_o;
         if (c === 1'b1 && p === 1'b0)
         begin
            if (t0 >= 0)
               break;
            t0 = i;
         end
         p = c;
      end
      chk(nm, exp, i - t0);
      if (i == 3000)
      begin
         chk("period_wait", 1, 0);
         complete_run;
      end
   endtask

   function automatic logic [15:0] cw(input int k);
      return 16'h9e37 + 16'(k) * 16'h03b5;
   endfunction

   //----------------------------------------
   // transfer run: two blocks, tx rewritten mid-run
   //----------------------------------------
   task automatic run_cfg(input int ws, input int frame_counter, input int bl, input int er);
      int          nw;
      int          k;
      int          base;
      logic [15:0] a[4];
      logic [15:0] b[4];
      logic [15:0] msk;
      nw  = bl + 1;
      msk = 16'hffff << (15 - ws);
      nbits    <= 5'(ws + 1);
      edge_r   <= er[0];
      cod_nrst <= 1'b0;
      @(posedge clk_sys);
      cod_nrst <= 1'b1;
      for (k = 0; k < 4; k++)
      begin
         a[k] = 16'($random(seed));
         b[k] = 16'($random(seed));
         wr(OFS_TX0 + 4'(k), a[k]);
      end
      wr(OFS_TMASK, 16'h0001);
      wr(OFS_RMASK, 16'h0001);
      wr(OFS_CTL3, 16'h0003);
      wr(OFS_CTL2, 16'((bl << 10) | (frame_counter << 5) | ws));
      capq.delete();
      base = n_irq;
      wr(OFS_CTL1, 16'h8000 | 16'(er << 9));
      wait_irq(base + 1);
      for (k = 0; k < nw; k++)
         wr(OFS_TX0 + 4'(k), b[k]);
      wait_irq(base + 2);
      for (k = 0; k < nw; k++)
         rdc("rx_word", OFS_RX0 + 4'(k), cw(k) & msk);
      wait_irq(base + 3);
      for (k = 0; k < nw; k++)
         rdc("rx_word", OFS_RX0 + 4'(k), cw(nw + k) & msk);
      wr(OFS_CTL1, 16'h0000);
      for (k = 0; k < 2 * nw; k++)
         chk("tx_word", {16'h0, (k < nw ? a[k] : b[k - nw]) & msk},
             {16'h0, capq.size() > k ? capq[k] : 16'hxxxx});
      $display("test transfer ws %0d done", ws);
   endtask

   //----------------------------------------
   // main sequence
   //----------------------------------------
   int   m;
   int   ch;
   logic s;
   int   divs[4] = '{2, 5, 1, 1};
   int   flen[4] = '{12, 12, 256, 256};

   initial
   begin
      repeat (10) @(posedge clk_sys);
      nrst     <= 1'b1;
      cod_nrst <= 1'b1;
      rdc("ctl1_rst", OFS_CTL1, RST_REG);
      rdc("ctl2_rst", OFS_CTL2, RST_REG);
      wr(OFS_TX0, 16'h1234);
      rdc("tx_read", OFS_TX0, 16'h0000);
      wr(OFS_RX0, 16'h5678);
      rdc("rx_write", OFS_RX0, 16'h0000);
      rdc("unmapped", 4'h3, 16'h0000);
      chk("sck_oe_idle", 0, {31'h0, pins.sck_oe});
      wr(OFS_CTL3, 16'h0005);
      period(0, 12, "sck_period");
      chk("sck_oe_div", 1, {31'h0, pins.sck_oe});
      wr(OFS_CTL1, 16'h0400);
      repeat (2) @(negedge clk_sys);
      chk("sck_oe_ext", 0, {31'h0, pins.sck_oe});
      wr(OFS_CTL1, 16'h0000);
      wr(OFS_CTL3, 16'h0000);
      repeat (3) @(negedge clk_sys);
      s  = pins.sck_o;
      ch = 0;
      repeat (40)
      begin
         @(negedge clk_sys);
         if (pins.sck_o !== s)
            ch++;
      end
      chk("sck_still", 0, ch);
      wr(OFS_CTL1, 16'h8100);
      repeat (2) @(negedge clk_sys);
      chk("fs_oe_slave", 0, {31'h0, pins.fs_oe});
      wr(OFS_CTL1, 16'h0000);
      $display("test registers done");
      for (m = 0; m < 4; m++)
      begin
         wr(OFS_CTL3, 16'(divs[m]));
         wr(OFS_CTL2, 16'h0043);
         wr(OFS_CTL1, 16'h8000 | 16'(m));
         period(1, 2 * (divs[m] + 1) * flen[m], "frame_len");
         chk("fs_oe_master", 1, {31'h0, pins.fs_oe});
         wr(OFS_CTL1, 16'h0000);
      end
      // slave: nothing runs until a sync edge arrives
      wr(OFS_CTL1, 16'h8100);
      rdbit("slave_idle", 14, 1'b0);
      @(posedge clk_sys);
      fs_ext <= 1'b1;
      repeat (8) @(posedge clk_sys);
      fs_ext <= 1'b0;
      rdbit("slave_run", 14, 1'b1);
      wr(OFS_CTL1, 16'h0000);
      rdc("status_off", OFS_STAT, 16'h0000);
      $display("test frame lengths done");
      run_cfg(15, 0, 1, 0);
      run_cfg(7, 1, 3, 1);
      complete_run;
   end
endmodule
